// >>> include/link_control_regs.vh
`ifndef LINK_CONTROL_REGS_VH
`define LINK_CONTROL_REGS_VH

`define LINK_CONTROL_OFFSET 12'h050
`define LC_PM_CTRL_LSB 0
`define LC_PM_CTRL_MSB 1
`define LC_RSVD2_BIT 2
`define LC_RCB_BIT 3
`define LC_LINK_OFF_BIT 4
`define LC_RETRAIN_BIT 5
`define LC_REFCLK_BIT 6
`define LC_PM_CTRL_RESET 2'h0
`define LC_PM_NONE 2'h0
`define LC_PM_L0S 2'h1
`define LC_PM_L1 2'h2
`define LC_PM_L0S_L1 2'h3
`define LC_RETRAIN_DELAY_NS 1000000
`define LC_CLK_PERIOD_NS 4
`define LC_RETRAIN_DELAY_CYCLES \
    (`LC_RETRAIN_DELAY_NS / `LC_CLK_PERIOD_NS)

`endif

// >>> rtl/link_control.v
`timescale 1ns/1ps
`include "link_control_regs.vh"

// Behaviour
// R1 - Power control resets disabled; EEPROM may override
// R2 - Power control codes: none, L0s, L1, both
// R3 - L0s enable gates transmitter entry only
// R4 - Completion boundary and bit 2 read zero
// R5 - Link off disables downstream link only
// R6 - Retrain write forces LTSSM into Recovery
// R7 - Retrain bit always reads zero
// R8 - Retrain write also updates other fields
// R9 - Settings busy in training apply next retrain
// R10 - Upstream retrain ignored while unlock clear
// R11 - Upstream retrain starts after 1 ms delay
// R12 - Software waits 1 ms after upstream retrain
// R13 - Upstream training flag asserts after delay
// R14 - Shared refclk bit read/write, resets zero
// R15 - Reserved, hardwired bits ignore writes, read zero
module link_control #(
    parameter integer RETRAIN_DELAY_CYCLES = `LC_RETRAIN_DELAY_CYCLES,
    parameter integer DELAY_WIDTH = 18
) (
    input wire CLK_SYS,
    input wire RST,
    input wire UPSTREAM_PORT,
    input wire CFG_WRITE,
    input wire CFG_READ,
    input wire [11:0] CFG_ADDR,
    input wire [15:0] CFG_WDATA,
    input wire [1:0] CFG_BYTE_EN,
    output reg [15:0] CFG_RDATA,
    output reg CFG_RVALID,
    input wire EEPROM_LOAD,
    input wire [1:0] EEPROM_PM_CTRL,
    input wire CONFIG_WRITE_UNLOCK,
    input wire LTSSM_IN_TRAINING,
    output reg [1:0] PM_CTRL,
    output reg TX_L0S_ENABLE,
    output reg RX_L0S_SUPPORT,
    output reg L1_ENABLE,
    output reg LINK_OFF,
    output reg SHARED_REFCLK,
    output reg LTSSM_GOTO_RECOVERY,
    output reg LINK_TRAINING_FLAG_SET,
    output reg RETRAIN_PENDING
);
    reg [1:0] pm_ctrl;
    reg link_off_request;
    reg shared_refclk_config;
    reg [1:0] pm_applied;
    reg link_off_applied;
    reg refclk_applied;
    reg deferred_apply;
    wire hit;
    wire wr_lo;
    wire retrain_write;
    wire up_retrain;
    wire local_retrain;
    wire delay_busy;
    wire delay_done;
    wire fire_retrain;
    reg [15:0] next_rdata;

    assign hit = (CFG_ADDR == `LINK_CONTROL_OFFSET);
    assign wr_lo = CFG_WRITE && hit && CFG_BYTE_EN[0];
    assign retrain_write = wr_lo && CFG_WDATA[`LC_RETRAIN_BIT]; // see R6
    // Upstream retrain needs unlock, then a delay
    assign up_retrain = retrain_write && UPSTREAM_PORT &&
        CONFIG_WRITE_UNLOCK; // see R10
    assign local_retrain = retrain_write && !UPSTREAM_PORT;
    assign fire_retrain = local_retrain || delay_done; // see R11

    retrain_delay #(
        .COUNT(RETRAIN_DELAY_CYCLES),
        .WIDTH(DELAY_WIDTH)
    ) u_delay (
        .clk(CLK_SYS),
        .rst(RST),
        .start(up_retrain),
        .busy(delay_busy),
        .done(delay_done)
    );

    function [15:0] pack_reg;
        input [1:0] pm;
        input off;
        input refclk;
        begin
            pack_reg = 16'h0000; // see R4 see R7 see R15
            pack_reg[`LC_PM_CTRL_MSB:`LC_PM_CTRL_LSB] = pm;
            pack_reg[`LC_LINK_OFF_BIT] = off;
            pack_reg[`LC_REFCLK_BIT] = refclk;
        end
    endfunction

    // Register fields, all updated by one write
    always @(posedge CLK_SYS) begin
        if (RST) begin
            pm_ctrl <= `LC_PM_CTRL_RESET; // see R1
            link_off_request <= 1'b0;
            shared_refclk_config <= 1'b0; // see R14
        end else if (wr_lo) begin
            pm_ctrl <= CFG_WDATA[`LC_PM_CTRL_MSB:`LC_PM_CTRL_LSB]; // see R8
            link_off_request <= CFG_WDATA[`LC_LINK_OFF_BIT];
            shared_refclk_config <= CFG_WDATA[`LC_REFCLK_BIT]; // see R14
        end else if (EEPROM_LOAD) begin
            pm_ctrl <= EEPROM_PM_CTRL; // see R1
        end
    end

    // Settings reach the link now, or at next retrain
    always @(posedge CLK_SYS) begin
        if (RST) begin
            pm_applied <= `LC_PM_CTRL_RESET;
            link_off_applied <= 1'b0;
            refclk_applied <= 1'b0;
            deferred_apply <= 1'b0;
        end else begin
            if (retrain_write && LTSSM_IN_TRAINING) begin
                deferred_apply <= 1'b1; // see R9
            end else if (fire_retrain && !LTSSM_IN_TRAINING) begin
                deferred_apply <= 1'b0;
            end
            if (!deferred_apply || (fire_retrain && !LTSSM_IN_TRAINING)) begin
                pm_applied <= pm_ctrl; // see R9
                link_off_applied <= link_off_request;
                refclk_applied <= shared_refclk_config;
            end
        end
    end

    always @* begin
        next_rdata = 16'h0000;
        if (hit) begin
            next_rdata = pack_reg(pm_ctrl, link_off_request,
                shared_refclk_config);
        end
    end

    // Outputs, all from flip-flops
    always @(posedge CLK_SYS) begin
        if (RST) begin
            CFG_RDATA <= 16'h0000;
            CFG_RVALID <= 1'b0;
            PM_CTRL <= `LC_PM_NONE;
            TX_L0S_ENABLE <= 1'b0;
            RX_L0S_SUPPORT <= 1'b1;
            L1_ENABLE <= 1'b0;
            LINK_OFF <= 1'b0;
            SHARED_REFCLK <= 1'b0;
            LTSSM_GOTO_RECOVERY <= 1'b0;
            LINK_TRAINING_FLAG_SET <= 1'b0;
            RETRAIN_PENDING <= 1'b0;
        end else begin
            CFG_RVALID <= CFG_READ;
            CFG_RDATA <= CFG_READ ? next_rdata : 16'h0000;
            PM_CTRL <= pm_applied; // see R2
            TX_L0S_ENABLE <= (pm_applied == `LC_PM_L0S) ||
                (pm_applied == `LC_PM_L0S_L1); // see R2 see R3
            RX_L0S_SUPPORT <= 1'b1; // see R3
            L1_ENABLE <= (pm_applied == `LC_PM_L1) ||
                (pm_applied == `LC_PM_L0S_L1); // see R2
            LINK_OFF <= link_off_applied && !UPSTREAM_PORT; // see R5
            SHARED_REFCLK <= refclk_applied;
            LTSSM_GOTO_RECOVERY <= fire_retrain; // see R6 see R11
            LINK_TRAINING_FLAG_SET <= fire_retrain; // see R13
            RETRAIN_PENDING <= delay_busy; // see R12
        end
    end
endmodule // link_control

// >>> rtl/retrain_delay.v
`timescale 1ns/1ps
module retrain_delay #(
    parameter integer COUNT = 250000,
    parameter integer WIDTH = 18
) (
    input wire clk,
    input wire rst,
    input wire start,
    output reg busy,
    output reg done
);
    reg [WIDTH-1:0] count;

    // Counts the deferral, then pulses done once
    always @(posedge clk) begin
        if (rst) begin
            count <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count <= COUNT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (busy) begin
                if (count == {WIDTH{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // retrain_delay

// >>> sim/link_control_chk.sv
`timescale 1ns/1ps
module link_control_chk #(parameter integer RETRAIN_DELAY_CYCLES = 20) (
    input wire CLK_SYS, RST, UPSTREAM_PORT, CONFIG_WRITE_UNLOCK,
    input wire CFG_WRITE, CFG_READ, CFG_RVALID, RETRAIN_PENDING,
    input wire LTSSM_GOTO_RECOVERY, LINK_TRAINING_FLAG_SET, RX_L0S_SUPPORT,
    input wire [15:0] CFG_WDATA, CFG_RDATA,
    input wire [11:0] CFG_ADDR,
    input wire [1:0] CFG_BYTE_EN
);
    localparam int FIRE = RETRAIN_DELAY_CYCLES + 2;
    wire rt = CFG_WRITE && CFG_ADDR == 12'h050 && CFG_BYTE_EN[0] &&
        CFG_WDATA[5] && !RETRAIN_PENDING;
    wire up = rt && UPSTREAM_PORT;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_rd; CFG_READ |=> CFG_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("no read");
    property p_zero; CFG_RVALID |-> (CFG_RDATA & 16'hffac) == 0; endproperty
    a_zero: assert property (p_zero) else $error("bits set");
    property p_dn; rt && !UPSTREAM_PORT |=> LTSSM_GOTO_RECOVERY; endproperty
    a_dn: assert property (p_dn) else $error("no retrain");
    property p_flag;
        LTSSM_GOTO_RECOVERY |-> LINK_TRAINING_FLAG_SET;
    endproperty
    a_flag: assert property (p_flag) else $error("no flag");
    property p_pend;
        up |-> ##2 RETRAIN_PENDING == CONFIG_WRITE_UNLOCK;
    endproperty
    a_pend: assert property (p_pend) else $error("pending");
    property p_late; up |=> !LINK_TRAINING_FLAG_SET [*8]; endproperty
    a_late: assert property (p_late) else $error("early");
    property p_fire;
        up && CONFIG_WRITE_UNLOCK |-> ##FIRE LTSSM_GOTO_RECOVERY;
    endproperty
    a_fire: assert property (p_fire) else $error("no fire");
    property p_rx; RX_L0S_SUPPORT; endproperty
    a_rx: assert property (p_rx) else $error("rx off");
endmodule // link_control_chk

bind link_control link_control_chk #(
    .RETRAIN_DELAY_CYCLES(RETRAIN_DELAY_CYCLES)) chk (.CLK_SYS, .RST,
    .UPSTREAM_PORT, .CONFIG_WRITE_UNLOCK, .CFG_WRITE, .CFG_READ,
    .CFG_RVALID, .RETRAIN_PENDING, .LTSSM_GOTO_RECOVERY, .RX_L0S_SUPPORT,
    .LINK_TRAINING_FLAG_SET, .CFG_WDATA, .CFG_RDATA, .CFG_ADDR,
    .CFG_BYTE_EN);

// >>> sim/link_control_test.sv
`timescale 1ns/1ps
module link_control_test;
    reg clk = 0, rst = 1, up = 0, wr = 0, rd = 0, ee = 0, unl = 0;
    reg [1:0] be = 2'h1;
    reg [11:0] adr = 12'h050;
    reg [15:0] wd = 16'h0000;
    wire [15:0] rdat;
    wire [1:0] pm;
    wire rv, txl, l1, off, rfc, go, pnd, trn, fl;
    integer bad_count = 0, n_tests = 0, cyc = 0, i, k;
    always #2 clk = ~clk;
    remote_port peer (.clk(clk), .go(go), .busy(trn));
    link_control #(.RETRAIN_DELAY_CYCLES(20)) uut (.CLK_SYS(clk),
        .RST(rst), .UPSTREAM_PORT(up), .CFG_WRITE(wr), .CFG_READ(rd),
        .CFG_ADDR(adr), .CFG_WDATA(wd), .CFG_BYTE_EN(be), .CFG_RDATA(rdat),
        .CFG_RVALID(rv), .EEPROM_LOAD(ee), .EEPROM_PM_CTRL(2'h2),
        .CONFIG_WRITE_UNLOCK(unl), .LTSSM_IN_TRAINING(trn), .PM_CTRL(pm),
        .TX_L0S_ENABLE(txl), .RX_L0S_SUPPORT(), .L1_ENABLE(l1),
        .LINK_OFF(off), .SHARED_REFCLK(rfc), .LTSSM_GOTO_RECOVERY(go),
        .LINK_TRAINING_FLAG_SET(fl), .RETRAIN_PENDING(pnd));
    task results; begin
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end endtask
    task chk(input [47:0] nm, input [15:0] e, s); begin
        n_tests = n_tests + 1;
        if (e !== s) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    end endtask
    task step; begin @(posedge clk); #1; end endtask
    task w(input [11:0] a, input [15:0] d); begin
        adr = a; wd = d; wr = 1; step; wr = 0;
    end endtask
    task r(input [15:0] e); begin
        adr = 12'h050; rd = 1; step; rd = 0;
        chk("rdata", e, rdat);
        chk("rvalid", 1, rv);
    end endtask
    task idle; begin
        k = 0;
        while (trn !== 0 && k < 20) begin step; k = k + 1; end
    end endtask
    task t_fields; begin
        r(16'h0000);
        w(12'h050, 16'hffff);
        chk("go", 1, go);
        step;
        step;
        chk("fields", 16'h000f, {off, rfc, pm});
        r(16'h0053);
    end endtask
    task t_codes; begin
        for (i = 0; i < 4; i = i + 1) begin
            w(12'h050, i[15:0]); step;
            step;
            chk("pm", {i[1], i[0], i[1:0]}, {l1, txl, pm});
        end
        w(12'h054, 16'h0000); be = 2'h2; step;
        w(12'h050, 16'h0000); be = 2'h1;
        r(16'h0003);
    end endtask
    task t_eeprom; begin
        ee = 1; step; ee = 0; step;
        step;
        chk("eeprom", 2, pm);
    end endtask
    task t_train; begin
        idle; w(12'h050, 16'h0020); step;
        w(12'h050, 16'h0021); step;
        step;
        chk("frozen", 0, pm);
        idle; w(12'h050, 16'h0021); step;
        chk("next", 1, pm);
    end endtask
    task t_up; begin
        idle; w(12'h050, 16'h0000); up = 1; step;
        w(12'h050, 16'h0030); step; step;
        chk("locked", 0, pnd);
        chk("off", 0, off);
        unl = 1; w(12'h050, 16'h0020); k = 0;
        while (go !== 1 && k < 40) begin step; k = k + 1; end
        chk("delay", 21, k);
        chk("flag", 1, fl);
    end endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            bad_count = bad_count + 1;
            results;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        t_fields;
        t_codes;
        t_eeprom;
        t_train;
        t_up;
        results;
    end
endmodule // link_control_test

// >>> sim/remote_port.sv
`timescale 1ns/1ps
module remote_port (
    input wire clk,
    input wire go,
    output wire busy
);
    reg [2:0] n = 3'h0;
    // Far end stays in recovery a few cycles
    always @(posedge clk) n <= go ? 3'h6 : n - {2'h0, busy};
    assign busy = n != 3'h0;
endmodule // remote_port
